// [design/lcd_frame_drive_control.sv]
// LCD frame drive control: blink, pin sharing, switches, frame timing
`timescale 1ns/100ps
`default_nettype none
`include "lcd_frame_defs.svh"

module lcd_frame_drive_control
#(
   parameter logic [1:0] PKG_OPTION = `PKG_LARGE,
   parameter int         PHASES     = 8
)
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       clk_lcd_tick_i,
   input  wire logic       clk_ps_tick_i,
   input  wire logic       half_lcd_i,
   input  wire logic       level_change_i,
   input  wire logic       controller_enable_i,
   input  wire logic       halt_mode_i,
   input  wire logic [1:0] blink_sel_i,
   input  wire logic [2:0] blink_rate_i,
   input  wire logic       eight_common_sel_i,
   input  wire logic [3:0] common_line_hi_i,
   input  wire logic [3:0] segment_line_hi_i,
   input  wire logic       pixel_data_i,
   input  wire logic [2:0] pixel_common_i,
   input  wire logic [5:0] pixel_segment_i,
   input  wire logic [2:0] drive_pulse_len_i,
   input  wire logic       permanent_high_drive_i,
   input  wire logic [2:0] contrast_code_i,
   input  wire logic       voltage_source_sel_i,
   input  wire logic [2:0] dead_phases_i,
   input  wire logic       frame_flag_clear_i,
   input  wire logic       frame_irq_enable_i,
   output logic [3:0]      shared_pin_o,
   output logic [5:0]      shared_seg_base_o,
   output logic            pixel_out_o,
   output logic            enable_switch_o,
   output logic            low_res_switch_o,
   output logic [2:0]      booster_code_o,
   output logic            booster_on_o,
   output logic            external_vlcd_o,
   output logic            dead_time_o,
   output logic [2:0]      phase_o,
   output logic            odd_frame_o,
   output logic            frame_flag_o,
   output logic            frame_irq_o
);
   localparam logic [2:0] LAST_PHASE = 3'(PHASES - 1);
   // Segment numbers carried by the shared pins, fixed per package
   localparam logic [5:0] SEG_BASE =
      (PKG_OPTION == `PKG_SMALL)  ? `SEG_BASE_SMALL  :
      (PKG_OPTION == `PKG_MIDDLE) ? `SEG_BASE_MIDDLE :
                                    `SEG_BASE_LARGE;

   lcd_frame_pkg::seq_state_t state_reg, state_next;
   logic [2:0]  phase_reg, phase_next;
   logic        odd_reg, odd_next;
   logic [2:0]  dead_reg, dead_next;
   logic        en_reg, en_next;
   logic        flag_reg, flag_next;
   logic        irq_reg, irq_next;
   logic [2:0]  cc_reg, cc_next;
   logic [`BLINK_CNT_W-1:0] bcnt_reg, bcnt_next;
   logic        bhalf_reg, bhalf_next;
   logic        boff_reg, boff_next;
   logic        pix_reg, pix_next;
   logic [3:0]  pin_reg, pin_next;
   logic        src_reg, src_next;
   logic        boost_reg, boost_next;
   logic        dt_reg, dt_next;
   logic        run, frame_start, blink_hit;
   logic [3:0]  blink_log2;

   // Halt stops the panel drive; waits keep it going
   assign run = controller_enable_i && !halt_mode_i;
   // Frame boundary is the tick that closes the last phase of a frame
   assign frame_start = clk_lcd_tick_i && phase_reg == LAST_PHASE
                        && state_reg == lcd_frame_pkg::ST_FRAME;
   assign blink_log2 = 4'(`BLINK_BASE_LOG2 + {1'b0, blink_rate_i});

   // ************************************************************
   // Frame sequencer
   // ************************************************************
   // Phases run on LCD ticks; dead time follows each odd frame
   always_comb
   begin
      state_next = state_reg;
      phase_next = phase_reg;
      odd_next   = odd_reg;
      dead_next  = dead_reg;
      en_next    = en_reg;
      flag_next  = flag_reg;
      if (frame_flag_clear_i)
         flag_next = 1'b0;
      unique case (state_reg)
         lcd_frame_pkg::ST_IDLE:
         begin
            phase_next = 3'h0;
            odd_next   = 1'b0;
            if (run)
            begin
               en_next    = 1'b1;
               state_next = lcd_frame_pkg::ST_FRAME;
            end
         end
         lcd_frame_pkg::ST_FRAME:
         begin
            if (run)
               en_next = 1'b1;
            if (clk_lcd_tick_i)
            begin
               if (phase_reg == LAST_PHASE - 3'h1 && !odd_reg)
                  flag_next = 1'b1;
               if (phase_reg != LAST_PHASE)
                  phase_next = phase_reg + 3'h1;
               else if (!odd_reg)
               begin
                  phase_next = 3'h0;
                  odd_next   = 1'b1;
                  if (!run)
                  begin
                     en_next    = 1'b0;
                     state_next = lcd_frame_pkg::ST_IDLE;
                  end
               end
               else
               begin
                  phase_next = 3'h0;
                  odd_next   = 1'b0;
                  dead_next  = dead_phases_i;
                  if (dead_phases_i != 3'h0)
                     state_next = lcd_frame_pkg::ST_DEAD;
               end
            end
         end
         lcd_frame_pkg::ST_DEAD:
         begin
            if (clk_lcd_tick_i)
            begin
               dead_next = dead_reg - 3'h1;
               if (dead_reg == 3'h1)
                  state_next = lcd_frame_pkg::ST_FRAME;
            end
         end
      endcase
      dt_next = state_next == lcd_frame_pkg::ST_DEAD;
   end

   // Flag set by hardware wins over a clear in the same cycle
   assign irq_next = flag_reg && frame_irq_enable_i;

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= lcd_frame_pkg::ST_IDLE;
         phase_reg <= 3'h0;
         odd_reg   <= 1'b0;
         dead_reg  <= 3'h0;
         en_reg    <= 1'b0;
         flag_reg  <= 1'b0;
         irq_reg   <= 1'b0;
         dt_reg    <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         odd_reg   <= odd_next;
         dead_reg  <= dead_next;
         en_reg    <= en_next;
         flag_reg  <= flag_next;
         irq_reg   <= irq_next;
         dt_reg    <= dt_next;
      end
   end

   // ************************************************************
   // Contrast, source, blink and pin sharing
   // ************************************************************
   // Contrast is latched only at frame start to avoid mid-frame steps
   always_comb
   begin
      cc_next    = frame_start ? contrast_code_i : cc_reg;
      src_next   = voltage_source_sel_i;
      boost_next = en_reg && !voltage_source_sel_i;
      bcnt_next  = bcnt_reg;
      bhalf_next = bhalf_reg;
      boff_next  = boff_reg;
      if (clk_lcd_tick_i)
      begin
         bcnt_next = bcnt_reg + 1'b1;
         // Half period is 2^(2+rate) LCD ticks, so blink is f_lcd / 2^(3+rate)
         if (bcnt_reg == `BLINK_CNT_W'((1 << (blink_log2 - 4'h1)) - 1))
         begin
            bcnt_next  = '0;
            bhalf_next = !bhalf_reg;
         end
      end
      if (frame_start)
         boff_next = bhalf_reg;
      unique case (blink_sel_i)
         `BLINK_OFF:    blink_hit = 1'b0;
         `BLINK_CORNER: blink_hit = pixel_common_i == 3'h0
                                    && pixel_segment_i == 6'h00;
         `BLINK_SEG0:   blink_hit = pixel_segment_i == 6'h00;
         `BLINK_ALL:    blink_hit = 1'b1;
      endcase
      // Only lit pixels are affected; data comes from memory
      pix_next = pixel_data_i && !(blink_hit && boff_reg)
                 && state_reg == lcd_frame_pkg::ST_FRAME;
      if (state_reg != lcd_frame_pkg::ST_FRAME)
         pin_next = 4'h0;
      else
         pin_next = eight_common_sel_i ? common_line_hi_i
                                       : segment_line_hi_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         cc_reg    <= `CONTRAST_RST;
         src_reg   <= 1'b0;
         boost_reg <= 1'b0;
         bcnt_reg  <= '0;
         bhalf_reg <= 1'b0;
         boff_reg  <= 1'b0;
         pix_reg   <= 1'b0;
         pin_reg   <= 4'h0;
         shared_seg_base_o <= 6'h00;
      end
      else
      begin
         cc_reg    <= cc_next;
         src_reg   <= src_next;
         boost_reg <= boost_next;
         bcnt_reg  <= bcnt_next;
         bhalf_reg <= bhalf_next;
         boff_reg  <= boff_next;
         pix_reg   <= pix_next;
         pin_reg   <= pin_next;
         shared_seg_base_o <= SEG_BASE;
      end
   end

   lcd_pulse_timer u_pulse
   (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .level_change_i (level_change_i && en_reg),
      .clk_ps_tick_i  (clk_ps_tick_i),
      .half_lcd_i     (half_lcd_i),
      .high_drive_i   (permanent_high_drive_i && en_reg),
      .pulse_len_i    (drive_pulse_len_i),
      .switch_o       (low_res_switch_o)
   );

   assign shared_pin_o    = pin_reg;
   assign pixel_out_o     = pix_reg;
   assign enable_switch_o = en_reg;
   assign booster_code_o  = cc_reg;
   assign booster_on_o    = boost_reg;
   assign external_vlcd_o = src_reg;
   assign dead_time_o     = dt_reg;
   assign phase_o         = phase_reg;
   assign odd_frame_o     = odd_reg;
   assign frame_flag_o    = flag_reg;
   assign frame_irq_o     = irq_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   a_en_closed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (run && state_reg != lcd_frame_pkg::ST_IDLE) |-> enable_switch_o)
      else $error("enable switch open while enabled");
   a_en_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ($fell(enable_switch_o)) |-> $past(odd_reg == 1'b0
       && phase_reg == LAST_PHASE))
      else $error("enable switch opened mid frame");
   a_cc_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!$past(frame_start)) |-> $stable(booster_code_o))
      else $error("contrast changed mid frame");
   a_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (clk_lcd_tick_i && state_reg == lcd_frame_pkg::ST_FRAME && !odd_reg
       && phase_reg == LAST_PHASE - 3'h1) |=> frame_flag_o)
      else $error("frame flag not set");
   a_dead_ground: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      dead_time_o |=> (shared_pin_o == 4'h0 && !pixel_out_o))
      else $error("lines not grounded in dead time");
   a_src_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> external_vlcd_o == $past(voltage_source_sel_i))
      else $error("voltage source mismatch");
   a_halt_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (halt_mode_i && state_reg == lcd_frame_pkg::ST_IDLE) |=> !enable_switch_o)
      else $error("panel driven in halt");
   a_blink_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (blink_sel_i == `BLINK_OFF && state_reg == lcd_frame_pkg::ST_FRAME)
      |=> pixel_out_o == $past(pixel_data_i))
      else $error("pixel blanked with blink off");
   c_flag: cover property (@(posedge clk_i) $rose(frame_flag_o));
   c_dead: cover property (@(posedge clk_i) $rose(dead_time_o));
   c_disable: cover property (@(posedge clk_i) $fell(enable_switch_o));
endmodule // lcd_frame_drive_control
`default_nettype wire

// [design/lcd_frame_defs.svh]
// Constants for the LCD frame drive control block
`ifndef LCD_FRAME_DEFS_SVH
`define LCD_FRAME_DEFS_SVH

// Blink select codes
`define BLINK_OFF        2'h0
`define BLINK_CORNER     2'h1
`define BLINK_SEG0       2'h2
`define BLINK_ALL        2'h3
// Blink divider: code 0 gives f_lcd/8, each step doubles
`define BLINK_BASE_LOG2  4'h3
`define BLINK_CNT_W      10
// Package options for the shared pins
`define PKG_LARGE        2'h0
`define PKG_MIDDLE       2'h1
`define PKG_SMALL        2'h2
`define SEG_BASE_LARGE   6'h28
`define SEG_BASE_MIDDLE  6'h24
`define SEG_BASE_SMALL   6'h18
// Reset value and phase width
`define CONTRAST_RST     3'h0
`define PHASE_W          3

`endif

// [design/lcd_frame_pkg.sv]
// Types for the LCD frame drive control block
package lcd_frame_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FRAME,
      ST_DEAD
   } seq_state_t;
endpackage

// [design/lcd_pulse_timer.sv]
// Low-resistance divider pulse timer
`timescale 1ns/100ps
`default_nettype none
`include "lcd_frame_defs.svh"

module lcd_pulse_timer
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       level_change_i,
   input  wire logic       clk_ps_tick_i,
   input  wire logic       half_lcd_i,
   input  wire logic       high_drive_i,
   input  wire logic [2:0] pulse_len_i,
   output logic            switch_o
);
   logic [2:0] left_reg;
   logic [2:0] left_next;
   logic       sw_reg;
   logic       sw_next;

   // ************************************************************
   // Pulse counter
   // ************************************************************
   // Counts prescaler pulses; cut short at half the LCD period
   always_comb
   begin
      left_next = left_reg;
      sw_next   = sw_reg;
      if (high_drive_i)
      begin
         sw_next   = 1'b1;
         left_next = 3'h0;
      end
      else if (level_change_i && pulse_len_i != 3'h0)
      begin
         sw_next   = 1'b1;
         left_next = pulse_len_i;
      end
      else if (half_lcd_i)
      begin
         sw_next   = 1'b0;
         left_next = 3'h0;
      end
      else if (clk_ps_tick_i && left_reg != 3'h0)
      begin
         left_next = left_reg - 3'h1;
         sw_next   = (left_reg != 3'h1);
      end
      else if (left_reg == 3'h0)
         sw_next = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         left_reg <= 3'h0;
         sw_reg   <= 1'b0;
      end
      else
      begin
         left_reg <= left_next;
         sw_reg   <= sw_next;
      end
   end

   assign switch_o = sw_reg;

   a_hd_closed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      high_drive_i |=> switch_o) else $error("high drive not closed");
   a_rl_open: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!high_drive_i && pulse_len_i == 3'h0 && $past(!high_drive_i)
       && $past(pulse_len_i == 3'h0) && !$past(switch_o))
      |-> !switch_o) else $error("rl switch closed with no drive");
   a_rl_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (level_change_i && !high_drive_i && pulse_len_i != 3'h0)
      |=> switch_o) else $error("rl pulse missing");
   a_rl_cap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (half_lcd_i && !high_drive_i && !level_change_i) |=> !switch_o)
      else $error("rl pulse beyond half period");
endmodule // lcd_pulse_timer
`default_nettype wire

// [bench/lcd_glass_panel.sv]
// Glass panel model: tallies samples where a driven pixel shows contrast
`timescale 1ns/100ps
`default_nettype none

module lcd_glass_panel
(
   input  wire logic clk_i,
   input  wire logic pixel_i,
   input  wire logic powered_i,
   input  wire logic grounded_i,
   output var  int   lit_o,
   output var  int   dark_o
);
   // ********************
   // Pixel response
   // ********************
   // A grounded or unpowered panel shows nothing, so it is not counted
   always @(posedge clk_i)
   begin
      if (powered_i === 1'h1 && grounded_i === 1'h0)
      begin
         if (pixel_i === 1'h1)
            lit_o <= lit_o + 1;
         else
            dark_o <= dark_o + 1; // Unknown data reads as dark
      end
   end
endmodule // lcd_glass_panel
`default_nettype wire

// [bench/lcd_frame_drive_control_tb.sv]
// Self-checking bench for the LCD frame drive control block
`timescale 1ns/100ps
`default_nettype none
`include "lcd_frame_defs.svh"

module lcd_frame_drive_control_tb;
   // ********************
   // Signals, design, panel
   // ********************
   localparam int PH = 4;      // Short frames keep the run brief
   logic       clk_i, sys_rst_i, clk_lcd_tick_i, clk_ps_tick_i;
   logic       half_lcd_i, level_change_i, controller_enable_i;
   logic       halt_mode_i, eight_common_sel_i, pixel_data_i;
   logic       permanent_high_drive_i, voltage_source_sel_i;
   logic       frame_flag_clear_i, frame_irq_enable_i, lc_en, prev;
   logic [1:0] blink_sel_i;
   logic [2:0] blink_rate_i, pixel_common_i, drive_pulse_len_i;
   logic [2:0] contrast_code_i, dead_phases_i, booster_code_o, phase_o, cc;
   logic [3:0] common_line_hi_i, segment_line_hi_i, shared_pin_o;
   logic [5:0] pixel_segment_i, shared_seg_base_o;
   logic       pixel_out_o, enable_switch_o, low_res_switch_o;
   logic       booster_on_o, external_vlcd_o, dead_time_o;
   logic       odd_frame_o, frame_flag_o, frame_irq_o;
   int         mismatches, checks, cnt, half_at, seed, dark, lit, n, tk, dc;
   logic [3:0] pin_q[$];
   logic [11:0] blink_tab [6];

   always #5 clk_i = ~clk_i;

   // Phase ticks every 32 cycles, prescaler every 2, half period mid-way
   always @(posedge clk_i)
   begin
      cnt            <= (cnt + 1) % 32;
      clk_lcd_tick_i <= (cnt == 31);
      clk_ps_tick_i  <= (cnt % 2 == 1);
      half_lcd_i     <= (cnt == half_at - 1);
      level_change_i <= lc_en && (cnt == 31);
   end

   lcd_frame_drive_control #(.PKG_OPTION(`PKG_LARGE), .PHASES(PH))
      i_lcd_frame_drive_control
   (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_lcd_tick_i(clk_lcd_tick_i),
      .clk_ps_tick_i(clk_ps_tick_i), .half_lcd_i(half_lcd_i),
      .level_change_i(level_change_i), .halt_mode_i(halt_mode_i),
      .controller_enable_i(controller_enable_i), .blink_sel_i(blink_sel_i),
      .blink_rate_i(blink_rate_i), .eight_common_sel_i(eight_common_sel_i),
      .common_line_hi_i(common_line_hi_i), .pixel_data_i(pixel_data_i),
      .segment_line_hi_i(segment_line_hi_i), .pixel_common_i(pixel_common_i),
      .pixel_segment_i(pixel_segment_i), .contrast_code_i(contrast_code_i),
      .drive_pulse_len_i(drive_pulse_len_i), .dead_phases_i(dead_phases_i),
      .permanent_high_drive_i(permanent_high_drive_i),
      .voltage_source_sel_i(voltage_source_sel_i),
      .frame_flag_clear_i(frame_flag_clear_i),
      .frame_irq_enable_i(frame_irq_enable_i), .shared_pin_o(shared_pin_o),
      .shared_seg_base_o(shared_seg_base_o), .pixel_out_o(pixel_out_o),
      .enable_switch_o(enable_switch_o), .low_res_switch_o(low_res_switch_o),
      .booster_code_o(booster_code_o), .booster_on_o(booster_on_o),
      .external_vlcd_o(external_vlcd_o), .dead_time_o(dead_time_o),
      .phase_o(phase_o), .odd_frame_o(odd_frame_o),
      .frame_flag_o(frame_flag_o), .frame_irq_o(frame_irq_o)
   );

   lcd_glass_panel i_lcd_glass_panel
   (
      .clk_i(clk_i), .pixel_i(pixel_out_o), .powered_i(enable_switch_o),
      .grounded_i(dead_time_o), .lit_o(lit), .dark_o(dark)
   );

   // ********************
   // Shared tasks
   // ********************
   task automatic chk_v(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int lo, input int hi,
                        input string what);
      checks++;
      if (got < lo || got > hi)
      begin
         mismatches++;
         $display("BAD %0t %s count %0d", $time, what, got);
      end
   endtask

   task automatic stop_test();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Sample just after the edge so that registered outputs have landed
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask

   task automatic clear_flag();
      @(posedge clk_i);
      frame_flag_clear_i <= 1'h1;
      @(posedge clk_i);
      frame_flag_clear_i <= 1'h0;
      step(2);
   endtask

   // Bounded wait for the flag, counting phase ticks and dead cycles
   task automatic wait_flag(output int ticks, output int dcyc);
      int i;
      ticks = 0;
      dcyc = 0;
      for (i = 0; i < 1200 && frame_flag_o !== 1'h1; i++)
      begin
         step(1);
         ticks += (clk_lcd_tick_i === 1'h1);
         dcyc += (dead_time_o === 1'h1);
      end
      if (i == 1200)
      begin
         mismatches++;
         stop_test();
      end
   endtask

   // One level change; counts cycles with the divider switch closed
   task automatic pulse(input logic [2:0] len, input int ha, output int m);
      m = 0;
      half_at = ha;
      @(posedge clk_i);
      drive_pulse_len_i <= len;
      lc_en             <= 1'h1;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge clk_i);
         if (i == 31)
            lc_en <= 1'h0;
         #1 m += (low_res_switch_o === 1'h1);
      end
   endtask

   // ********************
   // Main sequence
   // ********************
   initial
   begin
      {clk_i, clk_lcd_tick_i, clk_ps_tick_i, half_lcd_i, level_change_i,
       controller_enable_i, halt_mode_i, eight_common_sel_i, pixel_data_i,
       permanent_high_drive_i, voltage_source_sel_i, frame_flag_clear_i,
       frame_irq_enable_i, blink_sel_i, blink_rate_i, pixel_common_i,
       drive_pulse_len_i, contrast_code_i, dead_phases_i, common_line_hi_i,
       segment_line_hi_i, pixel_segment_i, lc_en} = '0;
      sys_rst_i = 1'h1;
      half_at   = 16;
      seed      = 32'h5283;
      // Select, common, segment, blinks: off, corner, seg 0, all
      blink_tab = '{12'h000, 12'h401, 12'h480, 12'h981, 12'h80A, 12'hE93};
      step(4);
      chk_v(enable_switch_o, 1'h0, "switch in reset");
      chk_v(frame_flag_o, 1'h0, "flag in reset");
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      step(2);
      chk_v(shared_seg_base_o, `SEG_BASE_LARGE, "seg base");
      // Shared pins are grounded while idle, so run the sequencer first
      @(posedge clk_i);
      controller_enable_i    <= 1'h1;
      permanent_high_drive_i <= 1'h1;
      step(2);
      chk_v(enable_switch_o, 1'h1, "enable switch");
      for (int i = 0; i < 24; i++)
      begin
         @(posedge clk_i);
         eight_common_sel_i <= 1'($random(seed));
         common_line_hi_i   <= 4'($random(seed));
         segment_line_hi_i  <= 4'($random(seed));
         step(2);
         pin_q.push_back(eight_common_sel_i ? common_line_hi_i
                                            : segment_line_hi_i);
         chk_v(shared_pin_o, pin_q.pop_front(), "pins");
      end
      pulse(3'h0, 16, n);
      chk_n(n, 64, 64, "high drive");
      @(posedge clk_i);
      permanent_high_drive_i <= 1'h0;
      pulse(3'h0, 16, n);
      chk_n(n, 0, 0, "no pulse");
      for (int l = 1; l < 8; l += 3)
      begin
         pulse(3'(l), 16, n);
         chk_n(n, 2 * l - 1, 2 * l + 1, "pulse length");
      end
      pulse(3'h7, 4, n);
      chk_n(n, 1, 6, "pulse cap");
      half_at = 16;
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk_i);
         voltage_source_sel_i <= v[0];
         step(2);
         chk_v(booster_on_o, !v[0], "booster");
         chk_v(external_vlcd_o, v[0], "external");
      end
      // Each dead count; irq enable alternates, contrast moves each pass
      cc = 3'h0;
      for (int d = 0; d < 8; d++)
      begin
         @(posedge clk_i);
         dead_phases_i      <= 3'(d);
         frame_irq_enable_i <= d[0];
         repeat (3)
         begin
            clear_flag();
            wait_flag(tk, dc);
         end
         chk_n(tk, 2 * PH + d, 2 * PH + d, "pair ticks");
         chk_n(dc, 32 * d, 32 * d, "dead cycles");
         chk_v(odd_frame_o, 1'h0, "flag frame");
         chk_v(phase_o, 3'(PH - 1), "flag phase");
         chk_v(booster_code_o, cc, "contrast applied");
         @(posedge clk_i);
         contrast_code_i <= cc + 3'h5;
         step(2);
         chk_v(frame_irq_o, d[0], "irq");
         chk_v(booster_code_o, cc, "contrast held");
         cc = cc + 3'h5;
      end
      @(posedge clk_i);
      dead_phases_i <= 3'h0;
      for (int b = 0; b < 6; b++)
      begin
         @(posedge clk_i);
         {blink_sel_i, pixel_common_i, pixel_segment_i} <= blink_tab[b][11:1];
         pixel_data_i <= 1'h1;
         step(512);
         n = dark;
         tk = lit;
         step(1280);
         n = dark - n;
         chk_n(n + lit - tk, 1280, 1280, "panel");
         if (blink_tab[b][0])
            chk_n(n, 320, 960, "blinking");
         else
            chk_n(n, 0, 0, "steady");
      end
      // Four blink periods must show three to five rising edges at rates 0 to 3
      for (int r = 0; r < 4; r++)
      begin
         @(posedge clk_i);
         blink_rate_i <= 3'(r);
         step(1024);
         n = 0;
         for (int k = 0; k < (1024 << r); k++)
         begin
            prev = pixel_out_o;
            step(1);
            n += (prev === 1'h0 && pixel_out_o === 1'h1);
         end
         chk_n(n, 3, 5, "blink rises");
      end
      // Halt stops the panel; booster reference assumed up
      @(posedge clk_i);
      halt_mode_i <= 1'h1;
      // Up to a whole frame pair runs on before the drive stops
      step(300);
      clear_flag();
      cc = phase_o;
      step(400);
      chk_v(phase_o, cc, "halted phase");
      chk_v(frame_flag_o, 1'h0, "halted flag");
      @(posedge clk_i);
      halt_mode_i <= 1'h0;
      wait_flag(tk, dc);
      chk_v(frame_flag_o, 1'h1, "resumed");
      @(posedge clk_i);
      controller_enable_i <= 1'h0;
      step(2);
      chk_v(enable_switch_o, 1'h1, "switch held");
      step(40);
      chk_v(enable_switch_o, 1'h0, "switch open");
      stop_test();
   end
endmodule // lcd_frame_drive_control_tb
`default_nettype wire
